// File: scnc_regs.sv
/*
  Serial programming, control and noise/spur registers of a fractional-N
  synthesizer, with reference path divider and digital lock detect.
  Assumes a three-wire link (serial clock, data, latch enable) and a
  reference pin, all asynchronous to clock; the phase error magnitude in
  ns arrives from logic on clock.
*/
`timescale 1ns/1ps
`default_nettype none

module scnc_regs
  import scnc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_en,
  input wire logic reference_input,
  input wire logic [7:0] cmp_err_ns,
  output logic counter_reset,
  output logic cp_three_state,
  output logic power_down,
  output logic lock_precision_select,
  output logic pd_polarity,
  output logic [3:0] cp_current,
  output logic doubler_en,
  output logic [3:0] resync_count,
  output logic dither_en,
  output logic cp_low_noise,
  output logic [8:0] int_value,
  output logic [11:0] fractional_numerator,
  output logic [11:0] fractional_modulus,
  output logic [11:0] resync_delay,
  output logic [3:0] ref_div,
  output logic [2:0] mux_select,
  output logic prescaler_sel,
  output logic fastlock,
  output logic phase_comparator_tick,
  output logic digital_lock
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  scnc_pin_sync #(
    .W(4)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin({reference_input, latch_en, ser_data, ser_clk}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic sclk_rise;
  logic sdata_lvl;
  logic le_rise;
  logic ref_rise;
  logic ref_fall;

  assign sclk_rise = pin_rise[0];
  assign sdata_lvl = pin_lvl[1];
  assign le_rise = pin_rise[2];
  assign ref_rise = pin_rise[3];
  assign ref_fall = pin_fall[3];

  ////////////////////////////////////////////////////////////////////////////
  // State

  scnc_state_t st_q;
  scnc_state_t st_d;

  // Decoded settings from the stored words
  logic ctl_cnt_rst;
  logic ctl_pwr_dn;
  logic ctl_prec;
  logic ctl_dbl;
  logic [3:0] ns_hi;
  logic ns_lo;
  logic quiet_mode;

  assign ctl_cnt_rst = st_q.ctrl[CTL_CNT_RST];
  assign ctl_pwr_dn = st_q.ctrl[CTL_PWR_DN];
  assign ctl_prec = st_q.ctrl[CTL_LOCK_PREC];
  assign ctl_dbl = st_q.ctrl[CTL_DOUBLER];
  // Noise mode of the word about to be latched
  assign ns_hi = st_q.shift[NS_HI_LSB +: 4];
  assign ns_lo = st_q.shift[NS_LO_BIT];
  assign quiet_mode = (ns_hi == NS_HI_QUIET);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic [1:0] sel;
  logic act_edge;
  logic [3:0] rdiv_eff;
  logic cnt_hold;
  logic new_channel;
  logic [5:0] lock_need;

  always_comb begin
    st_d = st_q;
    st_d.pfd_tick = 1'b0;
    sel = st_q.shift[1:0];
    new_channel = 1'b0;

    // Serial shifter, msb first
    if (sclk_rise) begin
      st_d.shift = {st_q.shift[WORD_W-2:0], sdata_lvl};
    end

    // Route the word on latch enable
    if (le_rise) begin
      unique case (sel)
        SEL_DIVIDER: begin
          st_d.int_v = st_q.shift[DIV_INT_LSB +: 9];
          st_d.fractional_numerator_v = st_q.shift[DIV_FRACTIONAL_NUMERATOR_LSB +: 12];
          st_d.fastlock = st_q.shift[DIV_FASTLOCK];
          st_d.mod_act = st_q.mod_pend;
          new_channel = 1'b1;
        end
        SEL_REFDIV: begin
          st_d.rdiv = st_q.shift[REF_R_LSB +: 4];
          st_d.presc = st_q.shift[REF_PRESC];
          st_d.muxsel = st_q.shift[REF_MUX_LSB +: 3];
          if (st_q.shift[REF_LOAD]) begin
            st_d.resync_dly = st_q.shift[REF_MOD_LSB +: 12];
          end else begin
            st_d.mod_pend = st_q.shift[REF_MOD_LSB +: 12];
          end
        end
        SEL_CONTROL: begin
          st_d.ctrl = st_q.shift;
        end
        SEL_NOISE: begin
          st_d.noise = st_q.shift;
          st_d.dither = ~quiet_mode;
          st_d.cp_quiet = quiet_mode & ns_lo;
        end
      endcase
    end

    // Active reference edges: falling only, or both with doubler
    act_edge = ctl_dbl ? (ref_rise | ref_fall) : ref_fall;
    rdiv_eff = (st_q.rdiv == 4'h0) ? 4'h1 : st_q.rdiv;
    cnt_hold = ctl_cnt_rst | ctl_pwr_dn;

    // Reference counter, held while counter reset is set
    if (cnt_hold) begin
      st_d.rcnt = 4'h0;
    end else if (act_edge) begin
      if (st_q.rcnt + 4'h1 >= rdiv_eff) begin
        st_d.rcnt = 4'h0;
        st_d.pfd_tick = 1'b1;
      end else begin
        st_d.rcnt = st_q.rcnt + 4'h1;
      end
    end

    // Lock qualification length by precision bit
    lock_need = ctl_prec ? LOCK_CNT_FINE : LOCK_CNT_COARSE;

    // Digital lock detect
    if (cnt_hold || new_channel) begin
      st_d.lock_cnt = 6'h00;
      st_d.locked = 1'b0;
    end else if (st_q.pfd_tick) begin
      if (st_q.locked) begin
        if (cmp_err_ns > UNLOCK_NS) begin
          st_d.locked = 1'b0;
          st_d.lock_cnt = 6'h00;
        end
      end else if (cmp_err_ns > LOCK_WIN_NS) begin
        st_d.lock_cnt = 6'h00;
      end else if (st_q.lock_cnt + 6'h01 >= lock_need) begin
        st_d.locked = 1'b1;
        st_d.lock_cnt = 6'h00;
      end else begin
        st_d.lock_cnt = st_q.lock_cnt + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.shift <= WORD_RST;
      st_q.ctrl <= WORD_RST;
      st_q.noise <= WORD_RST;
      st_q.mod_pend <= MOD_RST;
      st_q.mod_act <= MOD_RST;
      st_q.rdiv <= RDIV_RST;
      st_q.dither <= DITHER_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from stored state

  assign counter_reset = st_q.ctrl[CTL_CNT_RST];
  assign cp_three_state = st_q.ctrl[CTL_CP_TRI];
  assign power_down = st_q.ctrl[CTL_PWR_DN];
  assign lock_precision_select = st_q.ctrl[CTL_LOCK_PREC];
  assign pd_polarity = st_q.ctrl[CTL_POLARITY];
  assign cp_current = st_q.ctrl[CTL_CP_LSB +: 4];
  assign doubler_en = st_q.ctrl[CTL_DOUBLER];
  assign resync_count = st_q.ctrl[CTL_RESYNC_LSB +: 4];

  // Noise modes, registered when the noise word is latched
  assign dither_en = st_q.dither;
  assign cp_low_noise = st_q.cp_quiet;

  assign int_value = st_q.int_v;
  assign fractional_numerator = st_q.fractional_numerator_v;
  assign fractional_modulus = st_q.mod_act;
  assign resync_delay = st_q.resync_dly;
  assign ref_div = st_q.rdiv;
  assign mux_select = st_q.muxsel;
  assign prescaler_sel = st_q.presc;
  assign fastlock = st_q.fastlock;
  assign phase_comparator_tick = st_q.pfd_tick;
  assign digital_lock = st_q.locked;

endmodule // scnc_regs

`default_nettype wire

// File: scnc_pkg.sv
/*
  Package for the synthesizer control and noise/spur programming block:
  serial word layout, register field positions, lock detect figures,
  state type of the register block.
  Assumes a 24-bit serial word whose two low bits select the target register.
*/

package scnc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial word and target selection
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_DIVIDER = 2'h0;
  localparam logic [1:0] SEL_REFDIV = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_NOISE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTL_CNT_RST = 2;
  localparam int CTL_CP_TRI = 3;
  localparam int CTL_PWR_DN = 4;
  localparam int CTL_LOCK_PREC = 5;
  localparam int CTL_POLARITY = 6;
  localparam int CTL_CP_LSB = 7;
  localparam int CTL_DOUBLER = 11;
  localparam int CTL_RESYNC_LSB = 12;

  // Noise and spur mode fields
  localparam int NS_LO_BIT = 2;
  localparam int NS_HI_LSB = 6;
  localparam logic [3:0] NS_HI_QUIET = 4'hf;

  // Divider ratio register fields
  localparam int DIV_FRACTIONAL_NUMERATOR_LSB = 2;
  localparam int DIV_INT_LSB = 14;
  localparam int DIV_FASTLOCK = 23;

  // Reference divider register fields
  localparam int REF_MOD_LSB = 2;
  localparam int REF_R_LSB = 14;
  localparam int REF_PRESC = 18;
  localparam int REF_MUX_LSB = 20;
  localparam int REF_LOAD = 23;

  ////////////////////////////////////////////////////////////////////////////
  // Lock detect figures
  localparam logic [5:0] LOCK_CNT_COARSE = 6'h18;
  localparam logic [5:0] LOCK_CNT_FINE = 6'h28;
  localparam logic [7:0] LOCK_WIN_NS = 8'h0f;
  localparam logic [7:0] UNLOCK_NS = 8'h1e;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [23:0] WORD_RST = 24'h000000;
  localparam logic [11:0] MOD_RST = 12'h002;
  localparam logic [3:0] RDIV_RST = 4'h1;
  localparam logic DITHER_RST = 1'b1;

  // State of the register block
  typedef struct packed {
    logic [23:0] shift;
    logic [23:0] ctrl;
    logic [23:0] noise;
    logic [8:0] int_v;
    logic [11:0] fractional_numerator_v;
    logic fastlock;
    logic [11:0] mod_pend;
    logic [11:0] mod_act;
    logic [11:0] resync_dly;
    logic [3:0] rdiv;
    logic [2:0] muxsel;
    logic presc;
    logic [3:0] rcnt;
    logic pfd_tick;
    logic [5:0] lock_cnt;
    logic locked;
    logic dither;
    logic cp_quiet;
  } scnc_state_t;

endpackage

// File: scnc_pin_sync.sv
/*
  Two-flop synchroniser for a group of pins with edge detection.
  Assumes pins are asynchronous to clock; edges are taken from the
  second and third stage only.
*/
`timescale 1ns/1ps
`default_nettype none

module scnc_pin_sync #(
  parameter int W = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } scnc_sync_t;

  scnc_sync_t st_q;
  scnc_sync_t st_d;

  // Shift the pins through the stages
  always_comb begin
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edges from stable stages
  assign level = st_q.s2;
  assign rise = st_q.s2 & ~st_q.s3;
  assign fall = ~st_q.s2 & st_q.s3;

endmodule // scnc_pin_sync

`default_nettype wire

// File: scnc_regs_assertions.sv
/*
  Checker for the synthesizer register block, watching its ports only.
  Assumes one clock domain on clock with synchronous reset rst_n.
*/
`timescale 1ns/1ps
`default_nettype none

module scnc_regs_assertions
  import scnc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] cmp_err_ns,
  input wire logic counter_reset,
  input wire logic power_down,
  input wire logic lock_precision_select,
  input wire logic dither_en,
  input wire logic cp_low_noise,
  input wire logic [3:0] ref_div,
  input wire logic [11:0] fractional_modulus,
  input wire logic phase_comparator_tick,
  input wire logic digital_lock
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [5:0] run_q;

  // Counts good comparisons in a row, saturating
  always_ff @(posedge clock) begin
    if (!rst_n || counter_reset || power_down)
      run_q <= 6'h00;
    else if (phase_comparator_tick)
      run_q <= (cmp_err_ns > LOCK_WIN_NS) ? 6'h00 : run_q + 6'(run_q != 6'h3f);
  end

  // Counters held for two cycles in a row
  sequence s_held;
    (counter_reset || power_down) [*2];
  endsequence

  a_held_lock: assert property (s_held |-> !digital_lock)
    else $error("lock high while counters held");
  a_held_tick: assert property (s_held |-> !phase_comparator_tick)
    else $error("tick while counters held");
  a_low_noise: assert property (cp_low_noise |-> !dither_en)
    else $error("dither on in lowest noise");
  a_unlock_err: assert property (digital_lock && phase_comparator_tick &&
    cmp_err_ns > UNLOCK_NS |=> !digital_lock)
    else $error("lock kept after large error");
  a_lock_run: assert property ($rose(digital_lock) |-> run_q >=
    (lock_precision_select ? LOCK_CNT_FINE : LOCK_CNT_COARSE))
    else $error("lock before enough good cycles");
  a_lock_tick: assert property ($rose(digital_lock) |-> $past(phase_comparator_tick))
    else $error("lock rose without comparison");
  a_tick_single: assert property (phase_comparator_tick |=> !phase_comparator_tick)
    else $error("tick longer than one cycle");
  a_mod_buffer: assert property ($changed(fractional_modulus) |-> $stable(ref_div))
    else $error("modulus taken from reference write");
endmodule // scnc_regs_assertions

`default_nettype wire

// File: scnc_host_model.sv
/*
  Host side of the three-wire programming link.
  Assumes the block samples these pins with its own faster clock.
*/
`timescale 1ns/1ps
`default_nettype none

module scnc_host_model (
  output var logic ser_clk,
  output var logic ser_data,
  output var logic latch_en
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_en = 1'b0;
  end

  // Shifts a word msb first at a 400 ns period, then latches it
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      #100 ser_data = w[i];
      #100 ser_clk = 1'b1;
      #200 ser_clk = 1'b0;
    end
    ser_data = ~w[0]; // Released line shows no stale bit
    #200 latch_en = 1'b1;
    #400 latch_en = 1'b0;
    #200;
  endtask
endmodule // scnc_host_model

`default_nettype wire

// File: scnc_regs_tb.sv
/*
  Self-checking bench for the synthesizer register block.
  Assumes the host model drives the link and the bench the reference.
*/
`timescale 1ns/1ps
`default_nettype none

module scnc_regs_tb;
  logic clock, rst_n, ser_clk, ser_data, latch_en, reference_input;
  logic [7:0] cmp_err_ns;
  logic counter_reset, cp_three_state, power_down, lock_precision_select;
  logic pd_polarity, doubler_en, dither_en, cp_low_noise, prescaler_sel;
  logic fastlock, phase_comparator_tick, digital_lock;
  logic [3:0] cp_current, resync_count, ref_div;
  logic [8:0] int_value;
  logic [11:0] fractional_numerator, fractional_modulus, resync_delay;
  logic [2:0] mux_select;
  logic [1:0] ref_cnt = 2'h0;
  int n_errors = 0;
  int n_checks = 0;
  int tick_n = 0;
  int cyc = 0;

  scnc_host_model i_scnc_host_model (.ser_clk, .ser_data, .latch_en);

  scnc_regs i_scnc_regs (.clock, .rst_n, .ser_clk, .ser_data, .latch_en,
    .reference_input, .cmp_err_ns, .counter_reset, .cp_three_state, .power_down,
    .lock_precision_select, .pd_polarity, .cp_current, .doubler_en, .resync_count,
    .dither_en, .cp_low_noise, .int_value, .fractional_numerator, .fractional_modulus,
    .resync_delay, .ref_div, .mux_select, .prescaler_sel, .fastlock,
    .phase_comparator_tick, .digital_lock);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Reference toggles every 4 clocks, ticks counted, run time capped
  always @(posedge clock) begin
    ref_cnt <= ref_cnt + 2'h1;
    if (ref_cnt == 2'h3)
      reference_input <= ~reference_input;
    if (phase_comparator_tick === 1'b1)
      tick_n <= tick_n + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic wr(input logic [23:0] w);
    #1;
    i_scnc_host_model.send(w);
    @(posedge clock);
    #1;
  endtask

  task automatic next_tick;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      #1 k++;
    end while (phase_comparator_tick !== 1'b1 && k < 200);
    chk(k < 200, "no comparison tick");
    @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Power-up order with register contents after each write
  task automatic t_regs;
    chk(fractional_modulus === 12'h002 && ref_div === 4'h1, "reset values");
    wr(24'h000003);
    chk(dither_en === 1'b1 && cp_low_noise === 1'b0, "low spur");
    wr(24'h0003c3);
    chk(dither_en === 1'b0 && cp_low_noise === 1'b0, "low noise and spur");
    wr(24'h0003c7);
    chk(dither_en === 1'b0 && cp_low_noise === 1'b1, "lowest noise");
    wr(24'h00a546);
    chk(counter_reset === 1'b1 && cp_current === 4'ha && pd_polarity === 1'b1, "ctl");
    chk(resync_count === 4'ha && {power_down, cp_three_state} === 2'h0, "ctl rest");
    wr(24'h80848d);
    chk(resync_delay === 12'h123 && fractional_modulus === 12'h002, "resync");
    wr(24'h34bffd);
    chk(fractional_modulus === 12'h002 && ref_div === 4'h2, "modulus held");
    chk(mux_select === 3'h3 && prescaler_sel === 1'b1, "ref fields");
    wr(24'ha28078);
    chk(fractional_modulus === 12'hfff && int_value === 9'h08a, "modulus");
    chk(fractional_numerator === 12'h01e && fastlock === 1'b1, "divider fields");
  endtask

  // Ticks seen in 64 clocks for a control word
  task automatic t_ticks(input logic [23:0] w, input int exp);
    int base;
    wr(w);
    chk({counter_reset, power_down, cp_three_state} === {w[2], w[4], w[3]}, "ctl bits");
    chk(doubler_en === w[11], "doubler");
    @(posedge clock);
    #1 base = tick_n;
    repeat (64) @(posedge clock);
    #1 chk(tick_n - base == exp, "tick rate");
  endtask

  // Lock after a restart, hold at 30 ns, loss above 30 ns
  task automatic t_lock(input logic [23:0] w, input int need);
    int base;
    int k;
    cmp_err_ns <= 8'h10;
    wr(w | 24'h000004);
    wr(w);
    chk(lock_precision_select === w[5] && digital_lock === 1'b0, "restart");
    next_tick;
    next_tick;
    cmp_err_ns <= 8'h00;
    #1 base = tick_n;
    k = 0;
    do begin
      @(posedge clock);
      #1 k++;
    end while (digital_lock !== 1'b1 && k < 2000);
    chk(tick_n - base == need, "lock count");
    cmp_err_ns <= 8'h1e;
    next_tick;
    next_tick;
    @(posedge clock);
    #1 chk(digital_lock === 1'b1, "lock lost at 30 ns");
    cmp_err_ns <= 8'h1f;
    next_tick;
    #1 chk(digital_lock === 1'b0, "lock kept above 30 ns");
    cmp_err_ns <= 8'h00;
  endtask

  // Relock, then a new channel must drop lock while the error stays at 30 ns
  task automatic t_chan;
    int k;
    k = 0;
    while (digital_lock !== 1'b1 && k < 2000) begin
      @(posedge clock);
      #1 k++;
    end
    chk(digital_lock === 1'b1, "no relock");
    cmp_err_ns <= 8'h1e;
    wr(24'h228078);
    chk(digital_lock === 1'b0 && fastlock === 1'b0, "lock kept after new channel");
    cmp_err_ns <= 8'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    reference_input = 1'b0;
    cmp_err_ns = 8'h00;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs;
    t_ticks(24'h000542, 4);
    t_ticks(24'h000d42, 8);
    t_ticks(24'h00055e, 0);
    t_lock(24'h000542, 24);
    t_lock(24'h000562, 40);
    t_chan;
    conclude;
  end
endmodule // scnc_regs_tb

bind scnc_regs scnc_regs_assertions i_scnc_regs_assertions (.clock, .rst_n,
  .cmp_err_ns, .counter_reset, .power_down, .lock_precision_select, .dither_en,
  .cp_low_noise, .ref_div, .fractional_modulus, .phase_comparator_tick,
  .digital_lock);

`default_nettype wire
